// [verilog/mtap_top.sv]
// Test access port of a pipelined synchronous memory: controller, instruction,
// bypass, identification and boundary registers, pad float control and a
// buffered copy, for the memory clock side, of the low 32 bits of each boundary word updated while none is in flight.
// Assumes tck from the board scan controller, unrelated to mclk; pads arrive
// asynchronously to both clocks.
// Notes on behaviour
// - Sixteen-state controller resets itself at power-up; no test reset pin.
// - Undriven mode-select and data inputs behave exactly like logic one.
// - Scan only observes pads; stored memory data never driven out by test.
// - Registers: 3-bit instruction, 1-bit bypass, 32-bit ident, 75-bit boundary.
// - Code 000 selects boundary register and floats data pins for sampling.
// - Code 001 selects ident register; test data enters its first stage.
// - Code 010 selects boundary register and floats data pins.
// - Codes 011, 101, 110, 111 select bypass, cleared on update, loads shifted bit.
// - Code 100 selects boundary register; data pins stay under memory control.
// - Ident fields: revision 31:28, config 27:18, vendor 17:12, maker 11:1, one.
`timescale 1ns/1ps
`default_nettype none
module mtap_top
    import mtap_pkg::*;
#(
    parameter logic [ID_REV_HI-ID_REV_LO:0] ID_REV = 4'h0,
    parameter logic [ID_CFG_HI-ID_CFG_LO:0] ID_CFG = 10'h000,
    parameter logic [ID_VND_HI-ID_VND_LO:0] ID_VND = 6'h00,
    // Arbitrary maker code
    parameter logic [ID_MKR_HI-ID_MKR_LO:0] ID_MKR = 11'h2AA
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_drv,
    input wire logic tdi,
    input wire logic tdi_drv,
    output logic tdo_q,
    output logic tdo_oe_b_q,
    input wire logic [BSR_W-1:0] pad_i,
    output logic dq_hiz_q,
    output logic word_valid_q,
    input wire logic word_ready,
    output logic [WORD_W-1:0] word_data_q
);

    localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, ID_CFG, ID_VND, ID_MKR, ID_START_VAL};

    function automatic mtap_state_t mtap_next(input mtap_state_t s, input logic m);
        mtap_state_t n;
        n = ST_TLR;
        unique case (s)
            ST_TLR: n = m ? ST_TLR : ST_RTI;
            ST_RTI: n = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: n = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: n = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: n = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_RTI;
            default: n = ST_TLR;
        endcase
        return n;
    endfunction : mtap_next

    // Reserved code is steered to bypass so an illegal load stays harmless
    function automatic mtap_dec_t mtap_decode(input logic [IR_W-1:0] ir);
        mtap_dec_t d;
        d = '0;
        unique case (ir)
            IR_EXTEST, IR_SAMPLEZ: begin
                d.sel_bsr = 1'b1;
                d.float_dq = 1'b1;
            end
            IR_SAMPLE: d.sel_bsr = 1'b1;
            IR_IDCODE: d.sel_id = 1'b1;
            IR_BYPASS, IR_RESERVED, IR_BYPASS6, IR_BYPASS7: d.sel_byp = 1'b1;
        endcase
        return d;
    endfunction : mtap_decode

    // ---------------- Test clock domain ----------------
    mtap_state_t st_q;
    logic [IR_W-1:0] ir_q;
    logic [IR_W-1:0] ir_sh_q;
    logic byp_q;
    logic [ID_W-1:0] id_sh_q;
    logic [BSR_W-1:0] bsr_q;
    logic [BSR_W-1:0] pad_s1_q;
    logic [BSR_W-1:0] pad_s2_q;
    logic snd_req_q;
    logic [WORD_W-1:0] snd_word_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_q;
    logic float_q;

    wire tms_eff = tms | ~tms_drv;
    wire tdi_eff = tdi | ~tdi_drv;
    wire mtap_state_t st_d = mtap_next(st_q, tms_eff);
    wire mtap_dec_t dec = mtap_decode(ir_q);
    wire mtap_dec_t dec_sh = mtap_decode(ir_sh_q);
    wire in_tlr = (st_q == ST_TLR);
    wire cap_dr = (st_q == ST_CAP_DR);
    wire sh_dr = (st_q == ST_SH_DR);
    wire upd_dr = (st_q == ST_UPD_DR);
    wire cap_ir = (st_q == ST_CAP_IR);
    wire sh_ir = (st_q == ST_SH_IR);
    wire upd_ir = (st_q == ST_UPD_IR);
    wire snd_idle = (snd_req_q == ack_s2_q);
    wire snd_go = upd_dr && dec.sel_bsr && snd_idle;
    wire dr_out = dec.sel_bsr ? bsr_q[0] : (dec.sel_id ? id_sh_q[0] : byp_q);
    wire tdo_d = sh_ir ? ir_sh_q[0] : dr_out;

    // Power-up reset lands in the reset state; five ones also return there
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_TLR;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            ir_q <= IR_IDCODE;
            ir_sh_q <= '0;
        end else begin
            if (cap_ir) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (sh_ir) begin
                ir_sh_q <= {tdi_eff, ir_sh_q[IR_W-1:1]};
            end
            if (in_tlr) begin
                ir_q <= IR_IDCODE;
            end else if (upd_ir) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // Float request is registered before it crosses; a decoded bus could glitch
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            float_q <= 1'b0;
        end else if (in_tlr) begin
            float_q <= 1'b0;
        end else if (upd_ir) begin
            float_q <= dec_sh.float_dq;
        end
    end

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            byp_q <= 1'b0;
        end else if (upd_ir || (cap_dr && dec.sel_byp)) begin
            byp_q <= 1'b0;
        end else if (sh_dr && dec.sel_byp) begin
            byp_q <= tdi_eff;
        end
    end

    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            id_sh_q <= '0;
        end else if (cap_dr && dec.sel_id) begin
            id_sh_q <= ID_VALUE;
        end else if (sh_dr && dec.sel_id) begin
            id_sh_q <= {tdi_eff, id_sh_q[ID_W-1:1]};
        end
    end

    // Pads are asynchronous to the test clock
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            pad_s1_q <= '0;
            pad_s2_q <= '0;
        end else begin
            pad_s1_q <= pad_i;
            pad_s2_q <= pad_s1_q;
        end
    end

    // Boundary cells only observe pads; nothing here drives the memory data out
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            bsr_q <= '0;
        end else if (cap_dr && dec.sel_bsr) begin
            bsr_q <= pad_s2_q;
        end else if (sh_dr && dec.sel_bsr) begin
            bsr_q <= {tdi_eff, bsr_q[BSR_W-1:1]};
        end
    end

    // Test data out changes on the falling edge, enabled only while shifting
    always_ff @(negedge tck or negedge rst_b) begin
        if (!rst_b) begin
            tdo_q <= 1'b0;
            tdo_oe_b_q <= 1'b1;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_b_q <= ~(sh_ir | sh_dr);
        end
    end

    // Low 32 bits of the updated boundary word are offered to the memory clock by toggle handshake;
    // a further update while one is still in flight is not forwarded
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            snd_req_q <= 1'b0;
            snd_word_q <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            if (snd_go) begin
                snd_word_q <= bsr_q[WORD_W-1:0];
                snd_req_q <= ~snd_req_q;
            end
        end
    end

    // ---------------- Memory clock domain ----------------
    logic fl_s1_q;
    logic req_s1_q;
    logic req_s2_q;
    logic fifo_in_ready;

    wire fifo_in_valid = (req_s2_q != ack_q);
    wire fifo_push = fifo_in_valid && fifo_in_ready;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fl_s1_q <= 1'b0;
            dq_hiz_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            fl_s1_q <= float_q;
            dq_hiz_q <= fl_s1_q;
            req_s1_q <= snd_req_q;
            req_s2_q <= req_s1_q;
            ack_q <= ack_q ^ fifo_push;
        end
    end

    mtap_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_b(rst_b),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(snd_word_q),
        .out_valid_q(word_valid_q),
        .out_ready(word_ready),
        .out_data_q(word_data_q)
    );

    // ---------------- Checks ----------------
    tap_reset_seq_a: assert property (@(posedge tck) disable iff (!rst_b)
        tms_eff [*5] |=> st_q == ST_TLR)
        else $error("five high mode samples did not reach reset state");

    tlr_ir_load_a: assert property (@(posedge tck) disable iff (!rst_b)
        st_q == ST_TLR |=> ir_q == IR_IDCODE)
        else $error("reset state did not load ident instruction");

    undriven_mode_a: assert property (@(posedge tck) disable iff (!rst_b)
        (!tms_drv && st_q == ST_RTI) |=> st_q == ST_SEL_DR)
        else $error("undriven mode select not taken as one");

    ir_update_a: assert property (@(posedge tck) disable iff (!rst_b)
        st_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated from shift stage");

    bypass_clear_a: assert property (@(posedge tck) disable iff (!rst_b)
        st_q == ST_UPD_IR |=> !byp_q)
        else $error("bypass not cleared on instruction update");

    bypass_shift_a: assert property (@(posedge tck) disable iff (!rst_b)
        (sh_dr && dec.sel_byp) |=> byp_q == $past(tdi_eff))
        else $error("bypass did not load shifted bit");

    id_capture_a: assert property (@(posedge tck) disable iff (!rst_b)
        (cap_dr && dec.sel_id) |=> id_sh_q == ID_VALUE && id_sh_q[ID_START])
        else $error("ident capture value wrong");

    id_shift_in_a: assert property (@(posedge tck) disable iff (!rst_b)
        (sh_dr && dec.sel_id) |=> id_sh_q[ID_W-1] == $past(tdi_eff) ##1 1'b1)
        else $error("test data not entering first ident stage");

    float_decode_a: assert property (@(posedge tck) disable iff (!rst_b)
        (ir_q == IR_EXTEST || ir_q == IR_SAMPLEZ) |-> dec.float_dq && dec.sel_bsr)
        else $error("float instruction does not float data pins");

    sample_decode_a: assert property (@(posedge tck) disable iff (!rst_b)
        ir_q == IR_SAMPLE |-> !dec.float_dq && dec.sel_bsr && !dec.sel_byp)
        else $error("plain sample floated data pins");

    bsr_capture_a: assert property (@(posedge tck) disable iff (!rst_b)
        (cap_dr && dec.sel_bsr) |=> bsr_q == $past(pad_s2_q))
        else $error("boundary capture did not take pad values");

    tdo_enable_a: assert property (@(posedge tck) disable iff (!rst_b)
        (sh_dr && $past(sh_dr)) |-> !tdo_oe_b_q && tdo_q == dr_out)
        else $error("data out not driven while shifting");

    ir_shift_out_a: assert property (@(posedge tck) disable iff (!rst_b)
        sh_ir |-> !tdo_oe_b_q && tdo_q == ir_sh_q[0])
        else $error("instruction bit not on data out while shifting");

    tdo_idle_a: assert property (@(posedge tck) disable iff (!rst_b)
        !(sh_ir || sh_dr) |-> tdo_oe_b_q)
        else $error("data out enabled outside shift states");

    ir_capture_a: assert property (@(posedge tck) disable iff (!rst_b)
        cap_ir |=> ir_sh_q == IR_CAPTURE)
        else $error("instruction capture pattern wrong");

    bsr_shift_a: assert property (@(posedge tck) disable iff (!rst_b)
        (sh_dr && dec.sel_bsr) |=> bsr_q == {$past(tdi_eff), $past(bsr_q[BSR_W-1:1])})
        else $error("boundary register did not shift");

    float_track_a: assert property (@(posedge tck) disable iff (!rst_b)
        float_q == dec.float_dq)
        else $error("float request does not follow instruction");

    word_send_a: assert property (@(posedge tck) disable iff (!rst_b)
        snd_go |=> snd_word_q == bsr_q[WORD_W-1:0] && snd_req_q != $past(snd_req_q))
        else $error("updated boundary word not offered");

    word_drop_a: assert property (@(posedge tck) disable iff (!rst_b)
        (upd_dr && dec.sel_bsr && !snd_idle) |=> snd_req_q == $past(snd_req_q))
        else $error("update sent while previous word in flight");

    word_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (word_valid_q && !word_ready) |=> word_valid_q && $stable(word_data_q))
        else $error("buffered word not held for consumer");

endmodule : mtap_top
`default_nettype wire

// [verilog/mtap_pkg.sv]
// Constants, types and state codes of the memory test access port.
// Assumes nothing of its surroundings; imported whole by the top module, not by the word buffer.
package mtap_pkg;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 75;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 8;

    localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h3;
    localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] IR_RESERVED = 3'h5;
    localparam logic [IR_W-1:0] IR_BYPASS6 = 3'h6;
    localparam logic [IR_W-1:0] IR_BYPASS7 = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // Identification word field positions
    localparam int ID_REV_HI = 31;
    localparam int ID_REV_LO = 28;
    localparam int ID_CFG_HI = 27;
    localparam int ID_CFG_LO = 18;
    localparam int ID_VND_HI = 17;
    localparam int ID_VND_LO = 12;
    localparam int ID_MKR_HI = 11;
    localparam int ID_MKR_LO = 1;
    localparam int ID_START = 0;
    localparam logic ID_START_VAL = 1'b1;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } mtap_state_t;

    // Decoded instruction: which data register sits at the port, and pad float
    typedef struct packed {
        logic sel_bsr;
        logic sel_id;
        logic sel_byp;
        logic float_dq;
    } mtap_dec_t;

endpackage : mtap_pkg

// [verilog/mtap_fifo.sv]
// Word buffer with valid/ready on both sides and a registered head word.
// Assumes one clock and an asynchronous active-low reset shared with its user.
`timescale 1ns/1ps
`default_nettype none
module mtap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid_q,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data_q
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;

    wire push = in_valid && in_ready;
    wire load_head = (cnt_q != '0) && (!out_valid_q || out_ready);
    wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(load_head);

    assign in_ready = (cnt_q != FULL_CNT);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (push) begin
                wp_q <= (wp_q == LAST_PTR) ? '0 : wp_q + 1'b1;
            end
            if (load_head) begin
                rp_q <= (rp_q == LAST_PTR) ? '0 : rp_q + 1'b1;
                out_data_q <= mem_q[rp_q];
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
        end
    end

endmodule : mtap_fifo
`default_nettype wire

// [testbench/mtap_ctl_model.sv]
// Behavioural board scan controller that drives the memory test port.
// Assumes its tasks are called one at a time; tck stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module mtap_ctl_model (
    output logic tck,
    output logic tms,
    output logic tms_drv,
    output logic tdi,
    output logic tdi_drv,
    input wire logic tdo_q,
    input wire logic tdo_oe_b_q
);
    localparam time HALF = 24;
    logic oe_at_rise;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tms_drv = 1'b1;
        tdi = 1'b1;
        tdi_drv = 1'b1;
        oe_at_rise = 1'b1;
    end

    // One test clock period; lines change while tck is low, tdo is taken just before the rise
    task pulse(input logic t, input logic d, output logic o);
        tms = t;
        tdi = d;
        #HALF;
        o = tdo_q;
        oe_at_rise = tdo_oe_b_q;
        tck = 1'b1;
        #HALF;
        tck = 1'b0;
    endtask : pulse

    // Mode-select sequence, first bit in bit 0; data line toggles so stale values never pass
    task walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) pulse(seq[i], ~tdi, o);
    endtask : walk

    // From idle: shift n bits through instruction or data path, update, back to idle
    task scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout,
              output logic oe_hi);
        logic o;
        dout = '0;
        oe_hi = 1'b0;
        if (ir) walk(8'h03, 4); else walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], o);
            dout[i] = o;
            oe_hi = oe_hi | oe_at_rise;
        end
        walk(8'h01, 2);
    endtask : scan

    // Data scan with the data line left undriven; ones must enter the path
    task scan_float(input int n, output logic [127:0] dout);
        logic hi;
        tdi_drv = 1'b0;
        scan(1'b0, n, 128'h0, dout, hi);
        tdi_drv = 1'b1;
    endtask : scan_float

    // Lines left undriven must act as ones: five clocks reach reset, then idle
    task float_reset;
        tms_drv = 1'b0;
        tdi_drv = 1'b0;
        walk(8'h00, 5);
        tms_drv = 1'b1;
        tdi_drv = 1'b1;
        walk(8'h00, 1);
    endtask : float_reset
endmodule : mtap_ctl_model
`default_nettype wire

// [testbench/test_memory_test_access_port.sv]
// Self-checking bench for the memory test access port and its word buffer.
// Assumes the scan controller model drives the test port; the bench drives pads and consumer.
`timescale 1ns/1ps
`default_nettype none
module test_memory_test_access_port;
    import mtap_pkg::*;
    // Arbitrary identification values
    localparam logic [31:0] ID_EXP = {4'h3, 10'h155, 6'h2A, 11'h0F0, 1'b1};
    localparam logic [BSR_W-1:0] PAD = 75'h4_A5C3_0F96_1E2D_3B87;
    logic mclk, rst_b, tck, tms, tms_drv, tdi, tdi_drv, tdo_q, tdo_oe_b_q, dq_hiz_q;
    logic word_valid_q, word_ready;
    logic [WORD_W-1:0] word_data_q;
    logic [BSR_W-1:0] pad_i;
    int error_cnt, check_count, cycles;

    mtap_top #(.ID_REV(4'h3), .ID_CFG(10'h155), .ID_VND(6'h2A), .ID_MKR(11'h0F0)) DUT (
        .mclk(mclk), .rst_b(rst_b), .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi),
        .tdi_drv(tdi_drv), .tdo_q(tdo_q), .tdo_oe_b_q(tdo_oe_b_q), .pad_i(pad_i),
        .dq_hiz_q(dq_hiz_q), .word_valid_q(word_valid_q), .word_ready(word_ready),
        .word_data_q(word_data_q));
    mtap_ctl_model far (.tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv),
        .tdo_q(tdo_q), .tdo_oe_b_q(tdo_oe_b_q));

    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt = error_cnt + 1;
            conclude();
        end
    end

    task check(input logic [127:0] seen, input logic [127:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // Load an instruction, see the capture pattern, let float control settle
    task load_ir(input logic [IR_W-1:0] code);
        logic [127:0] o;
        logic hi;
        far.scan(1'b1, IR_W, {125'h0, code}, o, hi);
        check(o[IR_W-1:0], IR_CAPTURE);
        check(hi, 1'b0);
        repeat (10) @(posedge mclk);
    endtask : load_ir

    // Take buffered words one by one; they must come in order from base
    task drain(input int lo, input int hi, input logic [31:0] base);
        int got;
        got = 0;
        for (int w = 0; w < 60; w++) begin
            @(posedge mclk);
            #1;
            if (word_valid_q === 1'b1) begin
                check(word_data_q, base + got);
                got++;
                @(posedge mclk);
                word_ready <= 1'b1;
                @(posedge mclk);
                word_ready <= 1'b0;
                w = 0;
            end
        end
        check(got >= lo && got <= hi, 1'b1);
    endtask : drain

    task t_ident;
        logic [127:0] o;
        logic hi;
        far.walk(8'h00, 1);
        far.scan(1'b0, 64, {96'h0, 32'h5A5AC3C3}, o, hi);
        check(o[31:0], ID_EXP);
        check(o[63:32], 32'h5A5AC3C3);
        check(hi, 1'b0);
        check(tdo_oe_b_q, 1'b1);
        $display("ident test done");
    endtask : t_ident

    task t_bypass;
        logic [127:0] o;
        logic hi;
        logic [IR_W-1:0] codes [3];
        codes = '{IR_BYPASS, IR_BYPASS6, IR_BYPASS7};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            check(dq_hiz_q, 1'b0);
            far.scan(1'b0, 8, 128'hB6, o, hi);
            check(o[7:0], {7'h36, 1'b0});
        end
        $display("bypass test done");
    endtask : t_bypass

    task t_boundary;
        logic [127:0] o;
        logic hi;
        logic [IR_W-1:0] codes [3];
        logic floats [3];
        codes = '{IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE};
        floats = '{1'b1, 1'b1, 1'b0};
        foreach (codes[k]) begin
            @(posedge mclk);
            pad_i <= PAD ^ {72'h0, codes[k]};
            load_ir(codes[k]);
            check(dq_hiz_q, floats[k]);
            far.scan(1'b0, BSR_W, {96'h0, 32'hC0DE0000 + k}, o, hi);
            check(o[BSR_W-1:0], PAD ^ {72'h0, codes[k]});
            drain(1, 1, 32'hC0DE0000 + k);
        end
        $display("boundary test done");
    endtask : t_boundary

    // Eleven updates with the consumer stalled; nine or ten survive, in order
    task t_fill;
        logic [127:0] o;
        logic hi;
        for (int k = 0; k < 11; k++) far.scan(1'b0, BSR_W, {96'h0, 32'h5EED0000 + k}, o, hi);
        drain(FIFO_DEPTH + 1, FIFO_DEPTH + 2, 32'h5EED0000);
        $display("buffer test done");
    endtask : t_fill

    task t_float;
        logic [127:0] o;
        logic hi;
        load_ir(IR_EXTEST);
        far.float_reset();
        repeat (10) @(posedge mclk);
        check(dq_hiz_q, 1'b0);
        far.scan(1'b0, 32, 128'h0, o, hi);
        check(o[31:0], ID_EXP);
        far.scan_float(64, o);
        check(o[31:0], ID_EXP);
        check(o[63:32], 32'hFFFFFFFF);
        $display("undriven input test done");
    endtask : t_float

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        pad_i = '0;
        word_ready = 1'b0;
        error_cnt = 0;
        check_count = 0;
        cycles = 0;
        far.walk(8'h01, 1);
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        t_ident();
        t_bypass();
        t_boundary();
        t_fill();
        t_float();
        conclude();
    end
endmodule : test_memory_test_access_port
`default_nettype wire
